// *** pkg/obe_pkg.sv ***
// package of register map, field layouts, codes and carrier types for the overlay blend block
`default_nettype none
package obe_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PANEL    = 8'h20;
   localparam logic [7:0] IDX_MDEPTH   = 8'h40;
   localparam logic [7:0] IDX_MSTARTL  = 8'h42;
   localparam logic [7:0] IDX_MSTARTH  = 8'h44;
   localparam logic [7:0] IDX_ODEPTH   = 8'h50;
   localparam logic [7:0] IDX_OSTARTL  = 8'h52;
   localparam logic [7:0] IDX_OSTARTH  = 8'h54;
   localparam logic [7:0] IDX_OWIDTH   = 8'h56;
   localparam logic [7:0] IDX_OHEIGHT  = 8'h58;
   localparam logic [7:0] IDX_OXPOS    = 8'h5a;
   localparam logic [7:0] IDX_OYPOS    = 8'h5c;
   localparam logic [7:0] IDX_EFFECT   = 8'h60;
   localparam logic [7:0] IDX_BLEND    = 8'h62;
   localparam logic [7:0] IDX_TRANSP   = 8'h64;
   localparam logic [7:0] IDX_KEYLO    = 8'h66;
   localparam logic [7:0] IDX_KEYHI    = 8'h68;
   localparam logic [7:0] IDX_PALIDX   = 8'h6a;
   localparam logic [7:0] IDX_PALLO    = 8'h6c;
   localparam logic [7:0] IDX_PALHI    = 8'h6e;
   // field positions
   localparam int PANEL_COLOUR_BIT = 3;
   localparam int BUSY_BIT         = 3;
   localparam int PAL_TABLE_BIT    = 15;
   localparam int TRANSP_EN_BIT    = 0;
   // colour depth codes
   localparam logic [2:0] DEPTH_565     = 3'h1;
   localparam logic [2:0] DEPTH_24_LUT  = 3'h4;
   localparam logic [2:0] DEPTH_16_LUT  = 3'h5;
   localparam logic [2:0] DEPTH_8_LUT   = 3'h6;
   // effect codes
   localparam logic [2:0] EFF_BLANK     = 3'h0;
   localparam logic [2:0] EFF_SOLID     = 3'h1;
   localparam logic [2:0] EFF_FLASH1    = 3'h2;
   localparam logic [2:0] EFF_FLASH2    = 3'h3;
   localparam logic [2:0] EFF_FADEOUT   = 3'h4;
   localparam logic [2:0] EFF_FADEIN    = 3'h5;
   localparam logic [2:0] EFF_FADECONT  = 3'h6;
   localparam logic [6:0] ALPHA_MAX     = 7'h7f;
   localparam logic [7:0] ALPHA_UNITY   = 8'h80;
   localparam int         BLEND_SHIFT   = 7;
   localparam int         PAL_DEPTH     = 256;

   typedef enum logic [4:0] {
      ENG_IDLE  = 5'h01,
      ENG_FLASH = 5'h02,
      ENG_FIN   = 5'h04,
      ENG_FOUT  = 5'h08,
      ENG_WIND  = 5'h10
   } obe_eng_t;

   typedef struct packed {
      logic [15:0] panel, mDepth, mStartL, mStartH, oDepth, oStartL, oStartH;
      logic [15:0] oWidth, oHeight, oXPos, oYPos, effect, blend, transp;
      logic [15:0] keyLo, keyHi, palIdx, palLo;
   } obe_regs_t;

   // pixel position and raw layer words from the fetch side
   typedef struct packed {
      logic        valid;
      logic [10:0] x;
      logic [10:0] y;
      logic [23:0] mainRaw;
      logic [23:0] ovlRaw;
   } obe_pix_t;

   typedef struct packed {
      obe_regs_t   regs;
      obe_eng_t    eng;
      logic        armed;
      logic        fadeCont;
      logic        phaseShow;
      logic [6:0]  frameCnt;
      logic [6:0]  curAlpha;
      logic        primed;
      logic        slvErr;
      logic [31:0] rdData;
      logic        outValid;
      logic [23:0] outPixel;
   } obe_state_t;
endpackage : obe_pkg
`default_nettype wire

// *** hdl/obe_overlay_blend.sv ***
// overlay layer compositor with palettes, keying, blending and the flash and fade engine
`default_nettype none
module obe_overlay_blend (
   // clock, reset and freeze
   input  wire  logic              core_clk,
   input  wire  logic              rst_n,
   input  wire  logic              clkEn,
   // apb register slave
   input  wire  logic              psel,
   input  wire  logic              penable,
   input  wire  logic              pwrite,
   input  wire  logic [11:0]       paddr,
   input  wire  logic [31:0]       pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   // frame timing and pixel stream
   input  wire  logic              frameStart,
   input  wire  obe_pkg::obe_pix_t pixIn,
   // composited output and effect busy flag
   output logic                    outValid,
   output logic [23:0]             outPixel,
   output logic                    effectBusy
);
   obe_pkg::obe_state_t st;
   obe_pkg::obe_state_t next_st;

   // palettes: index 0 main layer, index 1 overlay layer
   logic [23:0] mainPal [obe_pkg::PAL_DEPTH];
   logic [23:0] ovlPal  [obe_pkg::PAL_DEPTH];

   logic        wrEn;
   logic        palWr;
   logic [7:0]  regIdx;
   logic        colourPanel;
   logic [2:0]  effCode;
   logic [6:0]  period;
   logic [6:0]  ratio;
   logic [6:0]  stepAmt;
   logic        periodHit;
   logic        stopReq;
   logic        keyHit;
   logic        inWin;
   logic        shown;
   logic [6:0]  alphaEff;
   logic [7:0]  alphaW;
   logic [23:0] mainColour;
   logic [23:0] ovlColour;
   logic [23:0] blended;
   logic [23:0] keyColour;

   // expand 5:6:5 to 8:8:8 by copying msbs into the low bits
   function automatic logic [23:0] expand565(input logic [15:0] w);
      expand565 = {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
   endfunction : expand565

   // per-layer colour resolve; sel picks which palette the layer owns
   function automatic logic [23:0] resolve(input logic sel, input logic [2:0] depth,
                                           input logic colour, input logic [23:0] raw);
      logic [23:0] src;
      src = (depth == obe_pkg::DEPTH_16_LUT) ? expand565(raw[15:0]) : raw;
      resolve = raw;
      if (depth == obe_pkg::DEPTH_24_LUT || depth == obe_pkg::DEPTH_16_LUT) begin
         if (sel) begin
            resolve = {ovlPal[src[23:16]][23:16], ovlPal[src[15:8]][15:8], ovlPal[src[7:0]][7:0]};
         end else begin
            resolve = {mainPal[src[23:16]][23:16], mainPal[src[15:8]][15:8], mainPal[src[7:0]][7:0]};
         end
      end else if (depth == obe_pkg::DEPTH_8_LUT && colour) begin
         resolve = sel ? ovlPal[raw[7:0]] : mainPal[raw[7:0]];
      end else if (depth == obe_pkg::DEPTH_565) begin
         resolve = expand565(raw[15:0]);
      end
   endfunction : resolve

   // register decode; the index sits at paddr[9:2]
   always_comb begin
      regIdx = paddr[9:2];
      wrEn   = pready && pwrite;
      palWr  = wrEn && regIdx == obe_pkg::IDX_PALHI;
   end

   // field views of the live registers, so mid-effect edits act at once
   always_comb begin
      colourPanel = st.regs.panel[obe_pkg::PANEL_COLOUR_BIT];
      effCode     = st.regs.effect[2:0];
      period      = st.regs.effect[15:9];
      ratio       = st.regs.blend[6:0];
      stepAmt     = 7'h01 << st.regs.blend[9:8];
      keyColour   = {st.regs.keyHi[7:0], st.regs.keyLo};
      stopReq     = effCode == obe_pkg::EFF_BLANK || effCode == obe_pkg::EFF_SOLID;
      periodHit   = frameStart && st.frameCnt == period;
   end

   // pixel side: palette resolve, window test, key test, blend
   always_comb begin
      mainColour = resolve(1'b0, st.regs.mDepth[2:0], colourPanel, pixIn.mainRaw);
      ovlColour  = resolve(1'b1, st.regs.oDepth[2:0], colourPanel, pixIn.ovlRaw);
      // unsigned compares keep an overlay that runs off the panel edge from wrapping
      inWin = ({5'h00, pixIn.x} >= st.regs.oXPos) && ({5'h00, pixIn.x} < st.regs.oXPos + st.regs.oWidth) &&
              ({5'h00, pixIn.y} >= st.regs.oYPos) && ({5'h00, pixIn.y} < st.regs.oYPos + st.regs.oHeight);
      keyHit = st.regs.transp[obe_pkg::TRANSP_EN_BIT] && ovlColour == keyColour;
      shown  = effCode != obe_pkg::EFF_BLANK && st.phaseShow;
      alphaEff = (st.eng != obe_pkg::ENG_IDLE || effCode >= obe_pkg::EFF_FADEOUT) ? st.curAlpha : ratio;
      // stretch 0..127 onto 0..128 so the maximum ratio passes the overlay unchanged
      alphaW = {1'b0, alphaEff} + {7'h00, alphaEff[6]};
   end

   // per-channel mix of overlay over main
   genvar ch;
   generate
      for (ch = 0; ch < 3; ch++) begin : g_mix
         logic [15:0] mixSum;
         always_comb begin
            mixSum = ovlColour[ch*8 +: 8] * alphaW + mainColour[ch*8 +: 8] * (obe_pkg::ALPHA_UNITY - alphaW);
            blended[ch*8 +: 8] = mixSum[obe_pkg::BLEND_SHIFT +: 8];
         end
      end
   endgenerate

   // next-state: registers, bus answer, effect engine and output pixel
   always_comb begin
      next_st = st;
      // bus: read data is captured once per transfer, then the access completes
      if (psel && !st.primed) begin
         next_st.primed = 1'b1;
         next_st.slvErr = 1'b0;
         next_st.rdData = 32'h0000_0000;
         unique case (regIdx)
            obe_pkg::IDX_PANEL:   next_st.rdData[15:0] = st.regs.panel;
            obe_pkg::IDX_MDEPTH:  next_st.rdData[15:0] = st.regs.mDepth;
            obe_pkg::IDX_MSTARTL: next_st.rdData[15:0] = st.regs.mStartL;
            obe_pkg::IDX_MSTARTH: next_st.rdData[15:0] = st.regs.mStartH;
            obe_pkg::IDX_ODEPTH:  next_st.rdData[15:0] = st.regs.oDepth;
            obe_pkg::IDX_OSTARTL: next_st.rdData[15:0] = st.regs.oStartL;
            obe_pkg::IDX_OSTARTH: next_st.rdData[15:0] = st.regs.oStartH;
            obe_pkg::IDX_OWIDTH:  next_st.rdData[15:0] = st.regs.oWidth;
            obe_pkg::IDX_OHEIGHT: next_st.rdData[15:0] = st.regs.oHeight;
            obe_pkg::IDX_OXPOS:   next_st.rdData[15:0] = st.regs.oXPos;
            obe_pkg::IDX_OYPOS:   next_st.rdData[15:0] = st.regs.oYPos;
            obe_pkg::IDX_EFFECT: begin
               next_st.rdData[15:0] = st.regs.effect;
               next_st.rdData[obe_pkg::BUSY_BIT] = st.eng != obe_pkg::ENG_IDLE;
            end
            obe_pkg::IDX_BLEND:   next_st.rdData[15:0] = st.regs.blend;
            obe_pkg::IDX_TRANSP:  next_st.rdData[15:0] = st.regs.transp;
            obe_pkg::IDX_KEYLO:   next_st.rdData[15:0] = st.regs.keyLo;
            obe_pkg::IDX_KEYHI:   next_st.rdData[15:0] = st.regs.keyHi;
            obe_pkg::IDX_PALIDX:  next_st.rdData[15:0] = st.regs.palIdx;
            obe_pkg::IDX_PALLO:   next_st.rdData[15:0] = st.regs.palLo;
            obe_pkg::IDX_PALHI:   next_st.rdData[15:0] = 16'h0000;
            default:              next_st.slvErr = 1'b1;
         endcase
      end
      if (pready) begin
         next_st.primed = 1'b0;
      end
      // register writes, only bits that exist are kept
      if (wrEn && !st.slvErr) begin
         unique case (regIdx)
            obe_pkg::IDX_PANEL:   next_st.regs.panel   = pwdata[15:0];
            obe_pkg::IDX_MDEPTH:  next_st.regs.mDepth  = {13'h0000, pwdata[2:0]};
            obe_pkg::IDX_MSTARTL: next_st.regs.mStartL = {pwdata[15:2], 2'h0}; // low bits forced aligned
            obe_pkg::IDX_MSTARTH: next_st.regs.mStartH = pwdata[15:0];
            obe_pkg::IDX_ODEPTH:  next_st.regs.oDepth  = {13'h0000, pwdata[2:0]};
            obe_pkg::IDX_OSTARTL: next_st.regs.oStartL = {pwdata[15:2], 2'h0};
            obe_pkg::IDX_OSTARTH: next_st.regs.oStartH = pwdata[15:0];
            obe_pkg::IDX_OWIDTH:  next_st.regs.oWidth  = pwdata[15:0];
            obe_pkg::IDX_OHEIGHT: next_st.regs.oHeight = pwdata[15:0];
            obe_pkg::IDX_OXPOS:   next_st.regs.oXPos   = pwdata[15:0];
            obe_pkg::IDX_OYPOS:   next_st.regs.oYPos   = pwdata[15:0];
            obe_pkg::IDX_EFFECT:  next_st.regs.effect  = {pwdata[15:9], 6'h00, pwdata[2:0]};
            obe_pkg::IDX_BLEND:   next_st.regs.blend   = {6'h00, pwdata[9:8], 1'b0, pwdata[6:0]};
            obe_pkg::IDX_TRANSP:  next_st.regs.transp  = {15'h0000, pwdata[0]};
            obe_pkg::IDX_KEYLO:   next_st.regs.keyLo   = pwdata[15:0];
            obe_pkg::IDX_KEYHI:   next_st.regs.keyHi   = {8'h00, pwdata[7:0]};
            obe_pkg::IDX_PALIDX:  next_st.regs.palIdx  = {pwdata[15], 7'h00, pwdata[7:0]};
            obe_pkg::IDX_PALLO:   next_st.regs.palLo   = pwdata[15:0];
            default: ;
         endcase
      end

      // frame counter only runs while an effect is active
      if (st.eng == obe_pkg::ENG_IDLE) begin
         next_st.frameCnt = 7'h00;
      end else if (frameStart) begin
         next_st.frameCnt = periodHit ? 7'h00 : st.frameCnt + 7'h01;
      end

      // effect engine
      unique case (st.eng)
         obe_pkg::ENG_IDLE: begin
            next_st.phaseShow = 1'b1;
            if (stopReq) begin
               next_st.armed = 1'b1;
            end else if (st.armed) begin
               next_st.armed    = 1'b0;
               next_st.fadeCont = effCode == obe_pkg::EFF_FADECONT;
               if (effCode == obe_pkg::EFF_FLASH1 || effCode == obe_pkg::EFF_FLASH2) begin
                  next_st.eng      = obe_pkg::ENG_FLASH;
                  next_st.curAlpha = ratio;
               end else if (effCode == obe_pkg::EFF_FADEOUT) begin
                  next_st.eng      = obe_pkg::ENG_FOUT;
                  next_st.curAlpha = ratio;
               end else if (effCode == obe_pkg::EFF_FADEIN || effCode == obe_pkg::EFF_FADECONT) begin
                  next_st.eng      = obe_pkg::ENG_FIN;
                  next_st.curAlpha = 7'h00;
               end
            end
         end
         obe_pkg::ENG_FLASH: begin
            if (stopReq) begin
               next_st.eng = obe_pkg::ENG_WIND;
            end else if (periodHit) begin
               // flash1 hides the overlay on the off phase, flash2 halves its blend
               if (effCode == obe_pkg::EFF_FLASH1) begin
                  next_st.phaseShow = !st.phaseShow;
                  next_st.curAlpha  = ratio;
               end else begin
                  next_st.phaseShow = 1'b1;
                  next_st.curAlpha  = (st.curAlpha == ratio) ? {1'b0, ratio[6:1]} : ratio;
               end
            end
         end
         obe_pkg::ENG_FIN: begin
            if (stopReq) begin
               next_st.eng = obe_pkg::ENG_WIND;
            end else if (periodHit) begin
               if ({1'b0, st.curAlpha} + {1'b0, stepAmt} >= {1'b0, ratio}) begin
                  next_st.curAlpha = ratio;
                  next_st.eng = st.fadeCont ? obe_pkg::ENG_FOUT : obe_pkg::ENG_IDLE;
               end else begin
                  next_st.curAlpha = st.curAlpha + stepAmt;
               end
            end
         end
         obe_pkg::ENG_FOUT: begin
            if (stopReq) begin
               next_st.eng = obe_pkg::ENG_WIND;
            end else if (periodHit) begin
               if (st.curAlpha <= stepAmt) begin
                  next_st.curAlpha = 7'h00;
                  next_st.eng = st.fadeCont ? obe_pkg::ENG_FIN : obe_pkg::ENG_IDLE;
               end else begin
                  next_st.curAlpha = st.curAlpha - stepAmt;
               end
            end
         end
         obe_pkg::ENG_WIND: begin
            // finish the running interval before going idle; phaseShow is forced on at once, so a hidden overlay can reappear mid-frame
            next_st.phaseShow = 1'b1;
            if (periodHit) begin
               next_st.eng      = obe_pkg::ENG_IDLE;
               next_st.armed    = 1'b1;
               next_st.curAlpha = ratio;
            end
         end
      endcase

      // composite: outside the window, blanked, or key-coloured shows main only
      next_st.outValid = pixIn.valid;
      if (pixIn.valid) begin
         next_st.outPixel = (inWin && shown && !keyHit) ? blended : mainColour;
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st       <= '0;
         st.eng   <= obe_pkg::ENG_IDLE;
         st.armed <= 1'b1;
      end else if (clkEn) begin
         st <= next_st;
      end
   end

   // palette write port; the high half commits the word to the chosen table
   always_ff @(posedge core_clk) begin
      if (clkEn && palWr) begin
         if (st.regs.palIdx[obe_pkg::PAL_TABLE_BIT]) begin
            ovlPal[st.regs.palIdx[7:0]] <= {pwdata[7:0], st.regs.palLo};
         end else begin
            mainPal[st.regs.palIdx[7:0]] <= {pwdata[7:0], st.regs.palLo};
         end
      end
   end

   // outputs
   always_comb begin
      pready     = psel && penable && st.primed && clkEn;
      prdata     = st.rdData;
      pslverr    = pready && st.slvErr;
      outValid   = st.outValid;
      outPixel   = st.outPixel;
      effectBusy = st.eng != obe_pkg::ENG_IDLE;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   blank_hides_a: assert property (clkEn && pixIn.valid && effCode == obe_pkg::EFF_BLANK |=>
      outPixel == $past(mainColour)) else $error("blank overlay leaked into output");
   solid_ovl_a: assert property (clkEn && pixIn.valid && inWin && shown && !keyHit && alphaEff == obe_pkg::ALPHA_MAX
      |=> outPixel == $past(ovlColour)) else $error("maximum ratio did not give solid overlay");
   key_pass_a: assert property (clkEn && pixIn.valid && keyHit |=> outPixel == $past(mainColour))
      else $error("key colour not transparent");
   busy_flash_a: assert property (st.eng == obe_pkg::ENG_FLASH |-> effectBusy)
      else $error("busy low during flash");
   wind_busy_a: assert property (clkEn && st.eng != obe_pkg::ENG_IDLE && stopReq && !periodHit |=> effectBusy)
      else $error("busy dropped before wind down");
   fadein_start_a: assert property ($rose(st.eng == obe_pkg::ENG_FIN) && $past(st.eng) == obe_pkg::ENG_IDLE
      |-> st.curAlpha == 7'h00) else $error("fade-in did not start at zero");
   fadeout_start_a: assert property ($rose(st.eng == obe_pkg::ENG_FOUT) && $past(st.eng) == obe_pkg::ENG_IDLE
      |-> st.curAlpha == $past(ratio)) else $error("fade-out did not start at ratio");
   period_count_a: assert property (clkEn && frameStart && st.eng != obe_pkg::ENG_IDLE && !periodHit
      |=> st.frameCnt == $past(st.frameCnt) + 7'h01) else $error("frame counter slipped");
   fade_step_a: assert property (clkEn && st.eng == obe_pkg::ENG_FIN && periodHit && !stopReq &&
      {1'b0, st.curAlpha} + {1'b0, stepAmt} < {1'b0, ratio}
      |=> st.curAlpha == $past(st.curAlpha) + $past(stepAmt)) else $error("fade step wrong");
endmodule : obe_overlay_blend
`default_nettype wire

// *** tb/tb.sv ***
// register-level testbench for the overlay blend block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic               core_clk, rst_n, clkEn, psel, penable, pwrite, frameStart;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata, rdv;
   logic               pready, pslverr, outValid, effectBusy, errv;
   logic [23:0]        outPixel;
   obe_pkg::obe_pix_t  pixIn;
   int                 err_total, samples_checked;
   localparam logic [23:0] MCOL = 24'h112233;
   localparam logic [23:0] OCOL = 24'haabbcc;

   obe_overlay_blend uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .frameStart(frameStart), .pixIn(pixIn), .outValid(outValid), .outPixel(outPixel), .effectBusy(effectBusy));

   // free-running 100 MHz clock
   always #5 core_clk = ~core_clk;

   task complete_run;
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; pready, prdata and pslverr are sampled at the rising edge that ends the access
   task apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= {16'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         complete_run();
      end
      rdv  = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one pixel in, composited result compared one cycle later
   task pix(input logic [10:0] x, input logic [10:0] y, input logic [23:0] exp);
      @(posedge core_clk);
      pixIn <= '{1'b1, x, y, MCOL, OCOL};
      @(posedge core_clk);
      pixIn.valid <= 1'b0;
      @(negedge core_clk);
      chk({31'h0, outValid}, 32'h1);                    // valid follows the pixel
      chk({8'h0, outPixel}, {8'h0, exp});
   endtask : pix

   // frame pulses spaced a few cycles apart
   task frames(input int k);
      repeat (k) begin
         @(posedge core_clk);
         frameStart <= 1'b1;
         @(posedge core_clk);
         frameStart <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
   endtask : frames

   // expected blend per channel, weight widened so that 127 means the overlay alone
   function automatic logic [23:0] mix(input logic [6:0] a);
      logic [15:0] w;
      logic [15:0] t;
      w = {9'h0, a} + {15'h0, a[6]};
      for (int i = 0; i < 3; i++) begin
         t = {8'h0, OCOL[i*8+:8]} * w + {8'h0, MCOL[i*8+:8]} * (16'h0080 - w);
         mix[i*8+:8] = t[14:7];
      end
   endfunction : mix

   task busy(input logic e);
      chk({31'h0, effectBusy}, {31'h0, e});
   endtask : busy

   initial begin
      core_clk = 1'b0; rst_n = 1'b0; clkEn = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; frameStart = 1'b0; pixIn = '0;
      err_total = 0; samples_checked = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, obe_pkg::IDX_EFFECT, 16'h0);
      chk(rdv, 32'h0);                                  // blank after reset
      apb(1'b0, 8'h01, 16'h0);
      chk({31'h0, errv}, 32'h1);
      chk(rdv, 32'h0);
      // word-aligned start address reads back as written; palettes are never touched
      apb(1'b1, obe_pkg::IDX_MSTARTL, 16'h1234);
      apb(1'b0, obe_pkg::IDX_MSTARTL, 16'h0);
      chk(rdv, 32'h0000_1234);
      // window at 10,10 size 4x4, solid ratio
      apb(1'b1, obe_pkg::IDX_OXPOS, 16'h000a);
      apb(1'b1, obe_pkg::IDX_OYPOS, 16'h000a);
      apb(1'b1, obe_pkg::IDX_OWIDTH, 16'h0004);
      apb(1'b1, obe_pkg::IDX_OHEIGHT, 16'h0004);
      apb(1'b1, obe_pkg::IDX_BLEND, 16'h007f);
      pix(11'd11, 11'd11, MCOL);                        // code zero hides
      apb(1'b1, obe_pkg::IDX_EFFECT, {13'h0, obe_pkg::EFF_SOLID});
      pix(11'd11, 11'd11, OCOL);                        // full ratio is solid
      pix(11'd10, 11'd13, OCOL);                        // window edges inside
      pix(11'd14, 11'd11, MCOL);                        // right of window
      pix(11'd11, 11'd14, MCOL);                        // below window
      apb(1'b1, obe_pkg::IDX_BLEND, 16'h0040);
      pix(11'd12, 11'd12, mix(7'd64));                  // half mix
      apb(1'b1, obe_pkg::IDX_TRANSP, 16'h0001);
      apb(1'b1, obe_pkg::IDX_KEYLO, OCOL[15:0]);
      apb(1'b1, obe_pkg::IDX_KEYHI, {8'h0, OCOL[23:16]});
      pix(11'd12, 11'd12, MCOL);                        // key colour is see-through
      apb(1'b1, obe_pkg::IDX_TRANSP, 16'h0000);
      // fade-in: ratio 16, step 8, period field 1 gives two frames a step
      apb(1'b1, obe_pkg::IDX_BLEND, 16'h0310);
      apb(1'b1, obe_pkg::IDX_EFFECT, {7'h01, 6'h0, obe_pkg::EFF_FADEIN});
      apb(1'b0, obe_pkg::IDX_EFFECT, 16'h0);
      chk({31'h0, rdv[obe_pkg::BUSY_BIT]}, 32'h1);     // busy while fading
      frames(1);
      pix(11'd12, 11'd12, MCOL);                        // starts from zero
      frames(1);
      pix(11'd12, 11'd12, mix(7'd8));                   // one step of eight
      frames(1);
      busy(1'b1);                                       // not yet at ratio
      frames(1);
      pix(11'd12, 11'd12, mix(7'd16));                  // stops at ratio
      busy(1'b0);                                       // one-shot ends
      // fade-out from solid, step changed mid-fade
      apb(1'b1, obe_pkg::IDX_EFFECT, {13'h0, obe_pkg::EFF_SOLID});
      apb(1'b1, obe_pkg::IDX_BLEND, 16'h0010);
      apb(1'b1, obe_pkg::IDX_EFFECT, {13'h0, obe_pkg::EFF_FADEOUT});
      pix(11'd12, 11'd12, mix(7'd16));                  // starts at ratio
      frames(1);
      apb(1'b1, obe_pkg::IDX_BLEND, 16'h0310);
      frames(1);
      pix(11'd12, 11'd12, mix(7'd7));                   // 16-1 then -8
      // flash stop: busy holds until the wind-down frame
      apb(1'b1, obe_pkg::IDX_EFFECT, {13'h0, obe_pkg::EFF_SOLID});
      apb(1'b1, obe_pkg::IDX_EFFECT, {13'h0, obe_pkg::EFF_FLASH1});
      frames(2);
      busy(1'b1);                                       // repeating effect
      apb(1'b1, obe_pkg::IDX_EFFECT, {13'h0, obe_pkg::EFF_SOLID});
      busy(1'b1);                                       // stop write not yet taken, still flashing
      frames(1);
      busy(1'b0);                                       // settled
      complete_run();
   end
endmodule : tb
`default_nettype wire
